// ===== core/dqdi_pkg.sv
package dqdi_pkg;
	// ---------------------------------------------------------------
	// command word layout
	// ---------------------------------------------------------------
	localparam int         DATA_W       = 32;
	localparam int         OP_LSB       = 24;
	localparam int         OP_W         = 8;
	localparam int         RLIM_LSB     = 0;
	localparam int         TLIM_LSB     = 8;
	localparam int         LIM_W        = 8;
	localparam int         BORD_BIT     = 16;
	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_NOP       = 8'h00;
	localparam logic [7:0] OP_NOP_LONG  = 8'h01;
	localparam logic [7:0] OP_HANG      = 8'h02;
	localparam logic [7:0] OP_IFSPEC    = 8'h03;
	localparam logic [7:0] OP_UC_ON     = 8'h04;
	localparam logic [7:0] OP_UC_OFF    = 8'h05;
	localparam logic [7:0] OP_UC_WRITE  = 8'h06;
	localparam logic [7:0] OP_PC_SET    = 8'h07;
	localparam logic [7:0] OP_CLR_EOF   = 8'h08;
	localparam logic [7:0] OP_WAIT_EOF  = 8'h09;
	localparam logic [7:0] OP_GRAB      = 8'h0a;
	localparam logic [7:0] OP_YIELD     = 8'h0b;
	localparam logic [7:0] OP_P_QUEUE   = 8'h0c;
	localparam logic [7:0] OP_V_QUEUE   = 8'h0d;
	localparam logic [7:0] OP_P_PEER    = 8'h0e;
	localparam logic [7:0] OP_V_PEER    = 8'h0f;
	localparam logic [7:0] OP_WAIT_XFER = 8'h10;
	localparam logic [1:0] EXTRA_LONG   = 2'h1;
	localparam logic [1:0] EXTRA_UCW    = 2'h2;
	// ---------------------------------------------------------------
	// controller and queue indices
	// ---------------------------------------------------------------
	localparam int         CTL_PIX      = 0;
	localparam int         CTL_TEX      = 1;
	localparam logic       Q_RASTER     = 1'b0;
	localparam logic       Q_TRANSFER   = 1'b1;
	// ---------------------------------------------------------------
	// apb register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_COUNT   = 8'h08;
	localparam logic [7:0] ADDR_IFACE   = 8'h0c;
	localparam logic [7:0] ADDR_PC      = 8'h10;
	localparam int         CTRL_EN_BIT  = 0;
	localparam int         CTRL_CLR_BIT = 1;
	localparam logic       CTRL_EN_RST  = 1'b1;
endpackage

// ===== core/dqdi_top.sv
// What this block does
// - each controller merges its raster and transfer queues into one sequencer stream.
// - a wait stalls its queue until the counter is nonzero, then decrements; signal increments.
// - pixel raster_hold_from_transfer: raster pixel wait, transfer pixel increment.
// - pixel transfer_hold_from_raster: transfer pixel wait, raster pixel increment.
// - texture raster_hold_from_transfer: raster texture wait, transfer texture increment.
// - texture transfer_hold_from_raster: transfer texture wait, raster texture increment.
// - pixel raster_hold_from_peer blocks raster queue; texture raster signal increments it.
// - texture raster_hold_from_peer blocks raster queue; pixel raster signal increments it.
// - pixel transfer_hold_from_peer blocks transfer queue; texture transfer signal increments.
// - texture transfer_hold_from_peer blocks transfer queue; pixel transfer signal increments.
// - preferred queue is served until blocked by a semaphore or wait_for_transfer.
// - an empty unblocked preferred queue keeps control; other queue is not read.
// - after reset both controllers prefer the transfer_queue.
// - pixel: grab makes issuing queue preferred, yield hands preference across.
// - texture: raster grab or transfer yield prefers raster, and vice versa.
// - a grab in the non-preferred queue obeys the same preference as any command.
// - texture accepts short and long no-ops and a hang that loops in place.
// - interface setup loads raster_limit, transfer_limit and byte_order_select.
// - one command enters microcode_load_mode, another leaves it for normal input.
// - microcode write stores two data words at the command's address.
// - microcode read loads the program counter; no contents readback in normal use.
// - clear command resets sticky end_of_frame; frame completion sets it.
// - wait-for-end-of-frame holds later queue commands until end_of_frame is set.
//
// The register addresses and register access over APB are this design's own decisions.
module dqdi_top #(
	parameter int CNT_W = 4,
	parameter int UC_AW = 8
) (
	input  wire logic                                   mclk_i,
	input  wire logic                                   srst_i,
	input  wire logic                                   psel_i,
	input  wire logic                                   penable_i,
	input  wire logic                                   pwrite_i,
	input  wire logic [7:0]                             paddr_i,
	input  wire logic [31:0]                            pwdata_i,
	output logic      [31:0]                            prdata_o,
	output logic                                        pready_o,
	output logic                                        pslverr_o,
	input  wire logic [3:0]                             queue_valid_i,
	input  wire logic [3:0][dqdi_pkg::DATA_W-1:0]       queue_data_i,
	output logic      [3:0]                             queue_ready_o,
	input  wire logic                                   frame_done_i,
	input  wire logic                                   xfer_busy_i,
	output logic      [1:0]                             seq_valid_o,
	output logic      [1:0][dqdi_pkg::DATA_W-1:0]       seq_data_o,
	output logic      [1:0]                             seq_from_transfer_o,
	output logic                                        end_of_frame_o,
	output logic                                        microcode_load_mode_o,
	output logic      [UC_AW-1:0]                       pc_o
);
	import dqdi_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [1:0][1:0][CNT_W-1:0] cross_cnt_reg;
	logic [1:0][1:0][CNT_W-1:0] peer_cnt_reg;
	logic [1:0]                 pref_reg;
	logic [1:0]                 lock_q_reg;
	logic [1:0][1:0]            words_left_reg;
	logic [1:0][1:0]            ready_reg;
	logic [1:0]                 hang_reg;
	logic                       eof_reg;
	logic                       load_mode_reg;
	logic [UC_AW-1:0]           pc_reg;
	logic [UC_AW-1:0]           uc_addr_reg;
	logic [DATA_W-1:0]          uc_word0_reg;
	logic [2*DATA_W-1:0]        ucode_mem [2**UC_AW];
	logic [LIM_W-1:0]           rlim_reg;
	logic [LIM_W-1:0]           tlim_reg;
	logic                       border_reg;
	logic                       en_reg;
	logic                       sw_clr_reg;
	logic [2:0]                 frame_sync_reg;
	logic [2:0]                 xfer_sync_reg;
	logic                       frame_lvl_reg;
	logic                       xfer_lvl_reg;
	logic [1:0]                 seq_valid_reg;
	logic [1:0][DATA_W-1:0]     seq_data_reg;
	logic [1:0]                 seq_src_reg;
	logic [31:0]                prdata_reg;
	logic                       pready_reg;
	logic                       pslverr_reg;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// a change counts only once the second and third stage agree
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			frame_sync_reg <= 3'h0;
			xfer_sync_reg  <= 3'h0;
			frame_lvl_reg  <= 1'b0;
			xfer_lvl_reg   <= 1'b0;
		end else begin
			frame_sync_reg <= {frame_sync_reg[1:0], frame_done_i};
			xfer_sync_reg  <= {xfer_sync_reg[1:0], xfer_busy_i};
			if (frame_sync_reg[1] == frame_sync_reg[2])
				frame_lvl_reg <= frame_sync_reg[2];
			if (xfer_sync_reg[1] == xfer_sync_reg[2])
				xfer_lvl_reg <= xfer_sync_reg[2];
		end
	end

	logic frame_rise;
	assign frame_rise = frame_sync_reg[1] == frame_sync_reg[2] && frame_sync_reg[2] && !frame_lvl_reg;

	// ---------------------------------------------------------------
	// head decode and queue choice
	// ---------------------------------------------------------------
	logic [1:0][1:0][7:0] head_op;
	logic [1:0][1:0]      head_blk;
	logic [1:0][1:0]      head_stall;
	logic [1:0][1:0]      take;
	logic [1:0]           pick_go;
	logic [1:0]           pick_q;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			for (int q = 0; q < 2; q++) begin
				head_op[c][q]    = queue_data_i[2*c+q][OP_LSB+:OP_W];
				take[c][q]       = ready_reg[c][q] && queue_valid_i[2*c+q];
				head_blk[c][q]   = queue_valid_i[2*c+q] && words_left_reg[c] == 2'h0 &&
					((head_op[c][q] == OP_P_QUEUE && cross_cnt_reg[c][q] == '0) ||
					 (head_op[c][q] == OP_P_PEER && peer_cnt_reg[c][q] == '0) ||
					 (head_op[c][q] == OP_WAIT_XFER && xfer_lvl_reg));
				// eof wait and hang hold the queue but do not pass preference
				head_stall[c][q] = queue_valid_i[2*c+q] && words_left_reg[c] == 2'h0 &&
					((head_op[c][q] == OP_WAIT_EOF && !eof_reg) ||
					 (c == CTL_TEX && head_op[c][q] == OP_HANG));
			end
			if (words_left_reg[c] != 2'h0) begin
				pick_q[c]  = lock_q_reg[c];
				pick_go[c] = queue_valid_i[2*c+lock_q_reg[c]];
			end else if (!head_blk[c][pref_reg[c]]) begin
				pick_q[c]  = pref_reg[c];
				pick_go[c] = queue_valid_i[2*c+pref_reg[c]] && !head_stall[c][pref_reg[c]];
			end else begin
				pick_q[c]  = !pref_reg[c];
				pick_go[c] = queue_valid_i[2*c+(!pref_reg[c])] && !head_blk[c][!pref_reg[c]] &&
					!head_stall[c][!pref_reg[c]];
			end
		end
	end

	// one word in flight per controller; halves peak rate but keeps ready registered
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ready_reg <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				ready_reg[c] <= '0;
				if (en_reg && ready_reg[c] == 2'h0 && pick_go[c])
					ready_reg[c][pick_q[c]] <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// interlock counters
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cross_cnt_reg <= '0;
			peer_cnt_reg  <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				for (int q = 0; q < 2; q++) begin
					// other queue of the same controller signals
					if (take[c][1-q] && words_left_reg[c] == 2'h0 && head_op[c][1-q] == OP_V_QUEUE &&
					    cross_cnt_reg[c][q] != '1)
						cross_cnt_reg[c][q] <= cross_cnt_reg[c][q] + 1'b1;
					else if (take[c][q] && words_left_reg[c] == 2'h0 && head_op[c][q] == OP_P_QUEUE)
						cross_cnt_reg[c][q] <= cross_cnt_reg[c][q] - 1'b1;
					// same queue of the peer controller signals
					if (take[1-c][q] && words_left_reg[1-c] == 2'h0 && head_op[1-c][q] == OP_V_PEER &&
					    !(take[c][q] && words_left_reg[c] == 2'h0 && head_op[c][q] == OP_P_PEER) &&
					    peer_cnt_reg[c][q] != '1)
						peer_cnt_reg[c][q] <= peer_cnt_reg[c][q] + 1'b1;
					else if (take[c][q] && words_left_reg[c] == 2'h0 && head_op[c][q] == OP_P_PEER &&
					    !(take[1-c][q] && words_left_reg[1-c] == 2'h0 && head_op[1-c][q] == OP_V_PEER))
						peer_cnt_reg[c][q] <= peer_cnt_reg[c][q] - 1'b1;
				end
			end
		end
	end
	// increment and wait hitting one counter together cancel, so neither is lost

	// ---------------------------------------------------------------
	// preference and multi-word commands
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pref_reg       <= {Q_TRANSFER, Q_TRANSFER};
			words_left_reg <= '0;
			lock_q_reg     <= '0;
			hang_reg       <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				hang_reg[c] <= head_stall[c][pref_reg[c]] && head_op[c][pref_reg[c]] == OP_HANG;
				for (int q = 0; q < 2; q++) begin
					if (take[c][q]) begin
						if (words_left_reg[c] != 2'h0) begin
							words_left_reg[c] <= words_left_reg[c] - 2'h1;
						end else begin
							lock_q_reg[c] <= q[0];
							if (head_op[c][q] == OP_GRAB)
								pref_reg[c] <= q[0];
							if (head_op[c][q] == OP_YIELD)
								pref_reg[c] <= !q[0];
							if (c == CTL_TEX && head_op[c][q] == OP_NOP_LONG)
								words_left_reg[c] <= EXTRA_LONG;
							if (c == CTL_TEX && head_op[c][q] == OP_UC_WRITE)
								words_left_reg[c] <= EXTRA_UCW;
						end
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// texture housekeeping
	// ---------------------------------------------------------------
	logic            tex_take;
	logic [DATA_W-1:0] tex_word;
	logic [7:0]      tex_op;
	logic            tex_head;
	assign tex_take = |take[CTL_TEX];
	assign tex_word = queue_data_i[2*CTL_TEX+(take[CTL_TEX][1] ? 1 : 0)];
	assign tex_op   = tex_word[OP_LSB+:OP_W];
	assign tex_head = words_left_reg[CTL_TEX] == 2'h0;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			load_mode_reg <= 1'b0;
			pc_reg        <= '0;
			uc_addr_reg   <= '0;
			uc_word0_reg  <= '0;
			rlim_reg      <= '0;
			tlim_reg      <= '0;
			border_reg    <= 1'b0;
		end else if (tex_take && tex_head) begin
			unique case (tex_op)
				OP_IFSPEC: begin
					rlim_reg   <= tex_word[RLIM_LSB+:LIM_W];
					tlim_reg   <= tex_word[TLIM_LSB+:LIM_W];
					border_reg <= tex_word[BORD_BIT];
				end
				OP_UC_ON:    load_mode_reg <= 1'b1;
				OP_UC_OFF:   load_mode_reg <= 1'b0;
				OP_UC_WRITE: uc_addr_reg   <= tex_word[UC_AW-1:0];
				OP_PC_SET:   pc_reg        <= tex_word[UC_AW-1:0];
				default: ;
			endcase
		end else if (tex_take && words_left_reg[CTL_TEX] == EXTRA_UCW) begin
			uc_word0_reg <= tex_word;
		end
	end

	logic uc_pending_reg;

	// contents stay write-only from the command stream
	always_ff @(posedge mclk_i) begin
		if (tex_take && words_left_reg[CTL_TEX] == EXTRA_LONG && uc_pending_reg)
			ucode_mem[uc_addr_reg] <= {tex_word, uc_word0_reg};
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i)
			uc_pending_reg <= 1'b0;
		else if (tex_take && tex_head)
			uc_pending_reg <= tex_op == OP_UC_WRITE;
	end

	// ---------------------------------------------------------------
	// sticky end of frame
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i)
			eof_reg <= 1'b0;
		else if (frame_rise)
			eof_reg <= 1'b1;
		else if (sw_clr_reg || (|take[CTL_PIX] && words_left_reg[CTL_PIX] == 2'h0 &&
		         head_op[CTL_PIX][take[CTL_PIX][1]] == OP_CLR_EOF) ||
		         (tex_take && tex_head && tex_op == OP_CLR_EOF))
			eof_reg <= 1'b0;
	end

	// ---------------------------------------------------------------
	// sequencer stream
	// ---------------------------------------------------------------
	function automatic logic is_local(input logic [7:0] op);
		is_local = op <= OP_WAIT_XFER;
	endfunction

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			seq_valid_reg <= '0;
			seq_data_reg  <= '0;
			seq_src_reg   <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				seq_valid_reg[c] <= 1'b0;
				if (|take[c] && words_left_reg[c] == 2'h0 &&
				    !is_local(head_op[c][take[c][1]]) && !(c == CTL_TEX && load_mode_reg)) begin
					seq_valid_reg[c] <= 1'b1;
					seq_data_reg[c]  <= queue_data_i[2*c+(take[c][1] ? 1 : 0)];
					seq_src_reg[c]   <= take[c][1];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// apb slave, one wait state
	// ---------------------------------------------------------------
	logic [31:0] rd_mux;
	logic        addr_ok;
	always_comb begin
		rd_mux  = 32'h0;
		addr_ok = 1'b1;
		unique case (paddr_i)
			ADDR_CTRL:   rd_mux = {31'h0, en_reg};
			ADDR_STATUS: rd_mux = {23'h0, hang_reg, pref_reg, xfer_lvl_reg, 2'h0, load_mode_reg, eof_reg};
			ADDR_COUNT:  rd_mux = 32'({peer_cnt_reg, cross_cnt_reg});
			ADDR_IFACE:  rd_mux = {15'h0, border_reg, tlim_reg, rlim_reg};
			ADDR_PC:     rd_mux = 32'(pc_reg);
			default:     addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
			en_reg      <= CTRL_EN_RST;
			sw_clr_reg  <= 1'b0;
		end else begin
			pready_reg  <= psel_i && penable_i && !pready_reg;
			pslverr_reg <= psel_i && penable_i && !pready_reg && !addr_ok;
			sw_clr_reg  <= 1'b0;
			if (psel_i && penable_i && !pready_reg) begin
				prdata_reg <= pwrite_i ? 32'h0 : rd_mux;
				if (pwrite_i && paddr_i == ADDR_CTRL) begin
					en_reg     <= pwdata_i[CTRL_EN_BIT];
					sw_clr_reg <= pwdata_i[CTRL_CLR_BIT];
				end
			end
		end
	end

	assign prdata_o              = prdata_reg;
	assign pready_o              = pready_reg;
	assign pslverr_o             = pslverr_reg;
	assign queue_ready_o         = ready_reg;
	assign seq_valid_o           = seq_valid_reg;
	assign seq_data_o            = seq_data_reg;
	assign seq_from_transfer_o   = seq_src_reg;
	assign end_of_frame_o        = eof_reg;
	assign microcode_load_mode_o = load_mode_reg;
	assign pc_o                  = pc_reg;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	for (genvar c = 0; c < 2; c++) begin : g_chk
		sequence s_grab(q);
			take[c][q] && words_left_reg[c] == 2'h0 && head_op[c][q] == OP_GRAB;
		endsequence
		property p_one_queue;
			@(posedge mclk_i) disable iff (srst_i) $onehot0(ready_reg[c]);
		endproperty
		a_one_queue: assert property (p_one_queue) else $error("both queues offered");
		property p_wait_nonzero;
			@(posedge mclk_i) disable iff (srst_i)
			take[c][0] && words_left_reg[c] == 2'h0 && head_op[c][0] == OP_P_QUEUE |->
			cross_cnt_reg[c][0] != '0 ##1 cross_cnt_reg[c][0] == $past(cross_cnt_reg[c][0]) - 1'b1;
		endproperty
		a_wait_nonzero: assert property (p_wait_nonzero) else $error("wait passed zero counter");
		property p_pref_kept;
			@(posedge mclk_i) disable iff (srst_i)
			$rose(ready_reg[c][!pref_reg[c]]) && words_left_reg[c] == 2'h0 |->
			$past(head_blk[c][pref_reg[c]]);
		endproperty
		a_pref_kept: assert property (p_pref_kept) else $error("unpreferred queue read");
		property p_grab;
			@(posedge mclk_i) disable iff (srst_i) s_grab(1) |=> pref_reg[c] == Q_TRANSFER;
		endproperty
		a_grab: assert property (p_grab) else $error("grab ignored");
		property p_eof_wait;
			@(posedge mclk_i) disable iff (srst_i)
			take[c][0] && words_left_reg[c] == 2'h0 && head_op[c][0] == OP_WAIT_EOF |-> $past(eof_reg);
		endproperty
		a_eof_wait: assert property (p_eof_wait) else $error("eof wait passed early");
	end

	property p_reset_pref;
		@(posedge mclk_i) $past(srst_i) |-> pref_reg == 2'h3 && cross_cnt_reg == '0 && peer_cnt_reg == '0;
	endproperty
	a_reset_pref: assert property (p_reset_pref) else $error("reset state wrong");
	property p_eof_sticky;
		@(posedge mclk_i) disable iff (srst_i)
		eof_reg && !sw_clr_reg && !tex_take && !(|take[CTL_PIX]) |=> eof_reg;
	endproperty
	a_eof_sticky: assert property (p_eof_sticky) else $error("eof dropped by itself");
	property p_load_on;
		@(posedge mclk_i) disable iff (srst_i) tex_take && tex_head && tex_op == OP_UC_ON |=> load_mode_reg [*1];
	endproperty
	a_load_on: assert property (p_load_on) else $error("load mode not entered");
endmodule

// ===== test/dqdi_gp_model.sv
module dqdi_gp_model (
	input  wire logic             mclk_i,
	input  wire logic             srst_i,
	input  wire logic [3:0]       queue_ready_i,
	output logic      [3:0]       queue_valid_o,
	output logic      [3:0][31:0] queue_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] fifo[4][$];
	task automatic push_word(input int i, input logic [31:0] w);
		fifo[i].push_back(w);
	endtask
	initial begin
		queue_valid_o = '0;
		queue_data_o = '0;
	end
	// idle data lines toggle so a stale word is never mistaken for a fresh one
	always @(posedge mclk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (srst_i) fifo[i].delete();
			else if (queue_ready_i[i] && queue_valid_o[i]) void'(fifo[i].pop_front());
			queue_valid_o[i] <= (fifo[i].size() != 0);
			queue_data_o[i] <= (fifo[i].size() != 0) ? fifo[i][0] : ~queue_data_o[i];
		end
	end
endmodule

// ===== test/testbench.sv
module testbench;
	import dqdi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0, fd = 0, xb = 0;
	logic [7:0] pa = '0;
	logic [31:0] pwd = '0, prd, rd;
	logic pready, perr, err, eof, ucm;
	logic [3:0] qv, qr;
	logic [3:0][31:0] qd;
	logic [1:0] sv, sft;
	logic [1:0][31:0] sd;
	logic [7:0] pc;
	int error_cnt = 0, n_tests = 0, cyc = 0, cnt0 = 0, cnt1 = 0;
	logic [31:0] obs[$];
	typedef struct {int q; logic [31:0] w; logic x; logic f; int e0; int e1;} dqdi_row_type;
	dqdi_row_type rows[20] = '{'{1,32'h20000001,0,0,1,0}, '{0,32'h20000002,0,0,1,0},
		'{1,32'h10000000,1,0,2,0}, '{0,32'h0a000000,1,0,2,0}, '{1,32'h20000003,0,0,2,0},
		'{0,32'h0b000000,0,0,3,0}, '{1,32'h0c000000,0,0,3,0}, '{1,32'h20000004,0,0,3,0},
		'{0,32'h0d000000,0,0,4,0}, '{3,32'h0b000000,0,0,4,0}, '{2,32'h0e000000,0,0,4,0},
		'{2,32'h20000005,0,0,4,0}, '{1,32'h0b000000,0,0,4,0}, '{0,32'h0f000000,0,0,4,1},
		'{2,32'h03015a3c,0,0,4,1}, '{2,32'h07000042,0,0,4,1}, '{2,32'h08000000,0,0,4,1},
		'{2,32'h09000000,0,0,4,1}, '{2,32'h20000006,0,0,4,1}, '{2,32'h00000000,0,1,4,2}};
	always #12.5 mclk_i = ~mclk_i;
	dqdi_top u_dqdi_top (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
		.pslverr_o(perr), .queue_valid_i(qv), .queue_data_i(qd), .queue_ready_o(qr),
		.frame_done_i(fd), .xfer_busy_i(xb), .seq_valid_o(sv), .seq_data_o(sd),
		.seq_from_transfer_o(sft), .end_of_frame_o(eof), .microcode_load_mode_o(ucm), .pc_o(pc));
	dqdi_gp_model u_dqdi_gp_model (.mclk_i(mclk_i), .srst_i(srst_i), .queue_ready_i(qr),
		.queue_valid_o(qv), .queue_data_o(qd));
	always @(posedge mclk_i) begin
		cyc++;
		if (sv[0] === 1'b1) begin
			cnt0++;
			obs.push_back(sd[0]);
		end
		if (sv[1] === 1'b1) cnt1++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// apb master: request held until pready seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge mclk_i);
		pen <= 1;
		do @(posedge mclk_i); while (pready !== 1'b1);
		rd = prd;
		err = perr;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic push(input int q, input logic [31:0] w);
		@(posedge mclk_i);
		u_dqdi_gp_model.push_word(q, w);
		repeat (12) @(posedge mclk_i);
	endtask
	task automatic final_report();
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk_i);
		srst_i <= 0;
		chk({30'h0, sv}, 32'h0);
		apb(0, ADDR_STATUS, 0);
		chk(rd & 32'h60, 32'h60);
		apb(0, ADDR_COUNT, 0);
		chk(rd, 32'h0);
		apb(0, 8'h40, 0);
		chk({31'h0, err}, 32'h1);
		foreach (rows[i]) begin
			xb <= rows[i].x;
			fd <= rows[i].f;
			// pin levels pass the synchroniser before the row's word arrives
			repeat (4) @(posedge mclk_i);
			push(rows[i].q, rows[i].w);
			chk(cnt0, rows[i].e0);
			chk(cnt1, rows[i].e1);
		end
		foreach (obs[i]) chk(obs[i], 32'h20000001 + i);
		apb(0, ADDR_IFACE, 0);
		chk(rd, 32'h00015a3c);
		chk(sd[1], 32'h20000006);
		chk({31'h0, sft[1]}, 32'h0);
		chk({31'h0, sft[0]}, 32'h1);
		chk({24'h0, pc}, 32'h42);
		chk({31'h0, eof}, 32'h1);
		apb(1, ADDR_CTRL, 32'h3);
		repeat (2) @(posedge mclk_i);
		chk({31'h0, eof}, 32'h0);
		push(2, 32'h04000000);
		chk({31'h0, ucm}, 32'h1);
		push(2, 32'h05000000);
		chk({31'h0, ucm}, 32'h0);
		final_report();
	end
endmodule
